// *** core/rfd_pkg.sv ***
`default_nettype none
package rfd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_DET = 6'h23;
	localparam logic [5:0] IDX_SYS = 6'h24;
	localparam logic [5:0] IDX_TEMP = 6'h25;
	localparam logic [5:0] IDX_CC = 6'h26;
	localparam logic [5:0] IDX_PWR = 6'h27;
	localparam logic [5:0] IDX_IRQ_ST = 6'h30;
	localparam logic [5:0] IDX_IRQ_CLR = 6'h31;
	localparam logic [5:0] IDX_IRQ_EN = 6'h32;
	// Field detector control layout
	localparam int DET_W = 15;
	localparam int DET_PD = 14;
	localparam int DET_SRC = 12;
	localparam int DET_LVL = 8;
	localparam int DET_REFU = 4;
	localparam int DET_REFL = 0;
	// Detection source codes
	localparam logic [1:0] SRC_NFC = 2'h0;
	localparam logic [1:0] SRC_RF = 2'h1;
	localparam logic [1:0] SRC_BOTH = 2'h2;
	localparam logic [1:0] SRC_FORCE = 2'h3;
	// System status layout
	localparam int SYS_REGOK = 9;
	localparam int SYS_ERR = 6;
	localparam int SYS_STANDBY = 5;
	localparam int SYS_BOOT = 0;
	// Temperature control layout
	localparam int TMP_W = 4;
	localparam int TMP_HYST = 3;
	localparam int TMP_ON = 2;
	localparam int TMP_SEL = 0;
	localparam logic [7:0] TRIP_85 = 8'h55;
	localparam logic [7:0] TRIP_115 = 8'h73;
	localparam logic [7:0] TRIP_125 = 8'h7D;
	localparam logic [7:0] TRIP_135 = 8'h87;
	// Card check result layout
	localparam int CC_W = 14;
	localparam int CC_GEAR = 10;
	localparam int CC_GAIN = 0;
	// Power control layout
	localparam int PWR_W = 20;
	localparam int PWR_CCW = 16;
	localparam int PWR_CMOD = 12;
	localparam int PWR_RMOD = 8;
	localparam int PWR_RCW = 4;
	localparam int PWR_MAX = 3;
	localparam int PWR_AMP = 1;
	localparam int PWR_REF = 0;
	// Interrupt bits
	localparam int IRQ_W = 5;
	localparam int IRQ_PARAM = 0;
	localparam int IRQ_SYNTAX = 1;
	localparam int IRQ_SEMANTIC = 2;
	localparam int IRQ_STANDBY = 3;
	localparam int IRQ_CC = 4;
	// Bus answers and reset value
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : rfd_pkg
`default_nettype wire

// *** core/rfd_regs.sv ***
// Notes on behaviour
// [RQ1] Source select: 0 NFC detector, 1 RF detector, 2 both, 3 forced present.
// [RQ2] Power-down bit switches the NFC level detector off.
// [RQ3] Four-bit detection level for NFC detector, reset zero.
// [RQ4] Two four-bit RF detector references, reset zero, read and write.
// [RQ5] Regulator ok status bit follows the regulator output pin.
// [RQ6] Parameter, syntax, semantic host errors set status bits 8, 7, 6.
// [RQ7] Flag set when standby entry refused because a field is present.
// [RQ8] Boot cause flags recorded on every boot.
// [RQ9] Sensor runs only while enable bit set; bit 3 adds hysteresis.
// [RQ10] Threshold select: 85, 115, 125, 135 degrees.
// [RQ11] Reading card check result launches a card check.
// [RQ12] Card check is a single-point detection without standby.
// [RQ13] Result shows power gear at 13:10 and gain value at 9:0.
// [RQ14] Writing card check result stores detection mode 2 reference.
// [RQ15] Carrier conductance codes for card and reader mode.
// [RQ16] Modulation conductance codes for card and reader mode.
// [RQ17] Reader carrier amplitude at 2:1, full swing at bit 3.
// [RQ18] Bit 0 references carrier amplitude to the transmitter supply.
// [RQ19] Reserved bits read zero; writes to them and status do nothing.
`timescale 1ns/10ps
`default_nettype none
module rfd_regs #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Analog detector and regulator pins
	input wire logic nfc_det_in,
	input wire logic rf_det_in,
	input wire logic regulator_ok_in,
	// Field detector settings
	output logic field_present,
	output logic nfc_detector_power_down,
	output logic [3:0] detect_level,
	output logic [3:0] level_detector_ref_upper,
	output logic [3:0] level_detector_ref_lower,
	// System events
	input wire logic param_error_ev,
	input wire logic syntax_error_ev,
	input wire logic semantic_error_ev,
	input wire logic standby_refused_ev,
	input wire logic boot_valid,
	input wire logic [4:0] boot_cause,
	// Temperature sensor
	output logic sensor_on,
	output logic sensor_hysteresis_on,
	output logic [1:0] temp_trip_sel,
	output logic [7:0] temp_trip_deg,
	// Card check
	output logic card_check_start,
	output logic card_check_single_shot,
	output logic [13:0] low_power_card_detect_ref,
	input wire logic card_check_done,
	input wire logic [3:0] power_gear_now,
	input wire logic [9:0] gain_control_value,
	// Transmitter
	input wire logic reader_mode,
	input wire logic tx_modulating,
	output logic [3:0] tx_conductance,
	output logic [1:0] reader_carrier_level,
	output logic reader_driver_full_swing,
	output logic carrier_ref_to_supply,
	// Interrupt
	output logic irq
);
	////////////////////////////////////////////////////////////////////
	logic [rfd_pkg::DET_W-1:0] det_ctl;
	logic [rfd_pkg::TMP_W-1:0] temp_ctl;
	logic [rfd_pkg::PWR_W-1:0] pwr_cfg;
	logic [rfd_pkg::CC_W-1:0] cc_result;
	logic [rfd_pkg::IRQ_W-1:0] irq_st;
	logic [rfd_pkg::IRQ_W-1:0] irq_en;
	logic [4:0] boot_flags;
	logic [2:0] err_flags;
	logic standby_flag;
	logic cc_busy;
	logic [2:0] nfc_s, rf_s, rok_s;
	logic nfc_f, rf_f, rok_f;
	logic aw_got, w_got;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nfc_s <= 3'h0;
			rf_s <= 3'h0;
			rok_s <= 3'h0;
			nfc_f <= 1'b0;
			rf_f <= 1'b0;
			rok_f <= 1'b0;
		end else begin
			nfc_s <= {nfc_s[1:0], nfc_det_in};
			rf_s <= {rf_s[1:0], rf_det_in};
			rok_s <= {rok_s[1:0], regulator_ok_in};
			if (nfc_s[1] == nfc_s[2]) nfc_f <= nfc_s[2];
			if (rf_s[1] == rf_s[2]) rf_f <= rf_s[2];
			if (rok_s[1] == rok_s[2]) rok_f <= rok_s[2]; // RQ5
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus handshakes and decode
	wire aw_hs = awvalid && awready;
	wire w_hs = wvalid && wready;
	wire ar_hs = arvalid && arready;
	wire wr_go = aw_got && w_got && !bvalid;
	wire [5:0] wr_idx = aw_addr_q[7:2];
	wire [5:0] rd_idx = araddr[7:2];
	wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire we_det = wr_go && wr_idx == rfd_pkg::IDX_DET;
	wire we_temp = wr_go && wr_idx == rfd_pkg::IDX_TEMP;
	wire we_cc = wr_go && wr_idx == rfd_pkg::IDX_CC;
	wire we_pwr = wr_go && wr_idx == rfd_pkg::IDX_PWR;
	wire we_clr = wr_go && wr_idx == rfd_pkg::IDX_IRQ_CLR;
	wire we_en = wr_go && wr_idx == rfd_pkg::IDX_IRQ_EN;
	wire wr_map = wr_idx == rfd_pkg::IDX_DET ||
		wr_idx == rfd_pkg::IDX_SYS || wr_idx == rfd_pkg::IDX_TEMP ||
		wr_idx == rfd_pkg::IDX_CC || wr_idx == rfd_pkg::IDX_PWR ||
		wr_idx == rfd_pkg::IDX_IRQ_ST || we_clr || we_en;
	wire [31:0] det_nx = ({17'h0_0000, det_ctl} & ~wmask) | (w_data_q & wmask);
	wire [31:0] tmp_nx = ({28'h000_0000, temp_ctl} & ~wmask) |
		(w_data_q & wmask);
	wire [31:0] cc_nx = ({18'h0_0000, low_power_card_detect_ref} & ~wmask) |
		(w_data_q & wmask);
	wire [31:0] pwr_nx = ({12'h000, pwr_cfg} & ~wmask) | (w_data_q & wmask);
	wire [31:0] en_nx = ({27'h000_0000, irq_en} & ~wmask) |
		(w_data_q & wmask);
	wire [4:0] clr_bits = we_clr ? (w_data_q[4:0] & wmask[4:0]) : 5'h00;
	wire rd_sys = ar_hs && rd_idx == rfd_pkg::IDX_SYS;
	wire rd_cc = ar_hs && rd_idx == rfd_pkg::IDX_CC;

	// Read mux; reserved bits are zero-filled
	wire [31:0] sys_word = {22'h00_0000, rok_f, err_flags, standby_flag,
		boot_flags}; // RQ19
	wire rd_map = rd_idx == rfd_pkg::IDX_DET || rd_idx == rfd_pkg::IDX_SYS ||
		rd_idx == rfd_pkg::IDX_TEMP || rd_idx == rfd_pkg::IDX_CC ||
		rd_idx == rfd_pkg::IDX_PWR || rd_idx == rfd_pkg::IDX_IRQ_ST ||
		rd_idx == rfd_pkg::IDX_IRQ_CLR || rd_idx == rfd_pkg::IDX_IRQ_EN;
	wire [31:0] rd_word =
		rd_idx == rfd_pkg::IDX_DET ? {17'h0_0000, det_ctl} :
		rd_idx == rfd_pkg::IDX_SYS ? sys_word :
		rd_idx == rfd_pkg::IDX_TEMP ? {28'h000_0000, temp_ctl} :
		rd_idx == rfd_pkg::IDX_CC ? {18'h0_0000, cc_result} : // RQ13
		rd_idx == rfd_pkg::IDX_PWR ? {12'h000, pwr_cfg} :
		rd_idx == rfd_pkg::IDX_IRQ_ST ? {27'h000_0000, irq_st} :
		rd_idx == rfd_pkg::IDX_IRQ_EN ? {27'h000_0000, irq_en} :
		rfd_pkg::ZERO32;

	////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			bvalid <= 1'b0;
			bresp <= rfd_pkg::RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= rfd_pkg::ZERO32;
			w_strb_q <= 4'h0;
		end else begin
			if (!aw_got && !bvalid) awready <= 1'b1;
			if (!w_got && !bvalid) wready <= 1'b1;
			if (aw_hs) begin
				aw_got <= 1'b1;
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (w_hs) begin
				w_got <= 1'b1;
				wready <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_go) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_map ? rfd_pkg::RESP_OKAY : rfd_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= rfd_pkg::ZERO32;
			rresp <= rfd_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_map ? rfd_pkg::RESP_OKAY : rfd_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	AST_RSV_SYS: assert property ( // RQ19
		rd_sys |=> rvalid && rdata[31:10] == 22'h00_0000)
		else $error("reserved status bits not zero");

	////////////////////////////////////////////////////////////////////
	// Software-written settings; status words take no writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_ctl <= '0; // RQ3 RQ4
			temp_ctl <= '0;
			pwr_cfg <= '0;
			low_power_card_detect_ref <= 14'h0000;
			irq_en <= '0;
		end else begin
			if (we_det) det_ctl <= det_nx[rfd_pkg::DET_W-1:0]; // RQ4 RQ19
			if (we_temp) temp_ctl <= tmp_nx[rfd_pkg::TMP_W-1:0];
			if (we_cc)
				low_power_card_detect_ref <= cc_nx[rfd_pkg::CC_W-1:0]; // RQ14
			if (we_pwr) pwr_cfg <= pwr_nx[rfd_pkg::PWR_W-1:0];
			if (we_en) irq_en <= en_nx[rfd_pkg::IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Field detection source
	wire [1:0] src_sel = det_ctl[rfd_pkg::DET_SRC +: 2];
	wire nfc_live = nfc_f && !det_ctl[rfd_pkg::DET_PD]; // RQ2
	wire next_field =
		src_sel == rfd_pkg::SRC_NFC ? nfc_live :
		src_sel == rfd_pkg::SRC_RF ? rf_f :
		src_sel == rfd_pkg::SRC_BOTH ? (nfc_live || rf_f) :
		1'b1; // RQ1

	always_ff @(posedge aclk) begin
		if (!aresetn) field_present <= 1'b0;
		else field_present <= next_field; // RQ1
	end

	assign nfc_detector_power_down = det_ctl[rfd_pkg::DET_PD]; // RQ2
	assign detect_level = det_ctl[rfd_pkg::DET_LVL +: 4]; // RQ3
	assign level_detector_ref_upper = det_ctl[rfd_pkg::DET_REFU +: 4];
	assign level_detector_ref_lower = det_ctl[rfd_pkg::DET_REFL +: 4];

	AST_SRC_FORCE: assert property ( // RQ1
		src_sel == rfd_pkg::SRC_FORCE |=> field_present)
		else $error("forced source did not report a field");
	AST_NFC_OFF: assert property ( // RQ2
		src_sel == rfd_pkg::SRC_NFC && det_ctl[rfd_pkg::DET_PD]
		|=> !field_present)
		else $error("powered-down detector still reports a field");

	////////////////////////////////////////////////////////////////////
	// Status flags: hardware set beats clear-on-read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_flags <= 5'h00;
			err_flags <= 3'h0;
			standby_flag <= 1'b0;
		end else begin
			if (boot_valid) boot_flags <= boot_cause; // RQ8
			err_flags <= (err_flags & ~{3{rd_sys}}) |
				{param_error_ev, syntax_error_ev, semantic_error_ev}; // RQ6
			standby_flag <= (standby_flag && !rd_sys) ||
				standby_refused_ev; // RQ7
		end
	end

	AST_ERR_SET: assert property ( // RQ6
		param_error_ev |=> err_flags[2] && irq_st[rfd_pkg::IRQ_PARAM])
		else $error("parameter error not recorded");
	AST_STANDBY_SET: assert property ( // RQ7
		standby_refused_ev |=> ##1 sys_word[rfd_pkg::SYS_STANDBY] ||
		$past(rd_sys))
		else $error("standby refusal flag lost");

	////////////////////////////////////////////////////////////////////
	// Temperature sensor controls
	assign sensor_on = temp_ctl[rfd_pkg::TMP_ON]; // RQ9
	assign sensor_hysteresis_on = temp_ctl[rfd_pkg::TMP_HYST]; // RQ9
	assign temp_trip_sel = temp_ctl[rfd_pkg::TMP_SEL +: 2];
	wire [7:0] next_trip =
		temp_trip_sel == 2'h0 ? rfd_pkg::TRIP_85 :
		temp_trip_sel == 2'h1 ? rfd_pkg::TRIP_115 :
		temp_trip_sel == 2'h2 ? rfd_pkg::TRIP_125 :
		rfd_pkg::TRIP_135; // RQ10

	always_ff @(posedge aclk) begin
		if (!aresetn) temp_trip_deg <= rfd_pkg::TRIP_85;
		else temp_trip_deg <= next_trip; // RQ10
	end

	AST_TRIP: assert property ( // RQ10
		temp_trip_sel == 2'h3 && $stable(temp_trip_sel) |=>
		temp_trip_deg == rfd_pkg::TRIP_135)
		else $error("trip point not 135");

	////////////////////////////////////////////////////////////////////
	// Card check launched by a read of the result word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			card_check_start <= 1'b0;
			cc_busy <= 1'b0;
			cc_result <= '0;
		end else begin
			card_check_start <= rd_cc; // RQ11
			if (rd_cc) cc_busy <= 1'b1; // RQ12
			else if (card_check_done) cc_busy <= 1'b0;
			if (card_check_done)
				cc_result <= {power_gear_now, gain_control_value}; // RQ13
		end
	end

	// Single point, no standby, for as long as the check runs
	assign card_check_single_shot = cc_busy; // RQ12

	AST_CC_LAUNCH: assert property ( // RQ11
		rd_cc |=> card_check_start ##1 !card_check_start || rd_cc)
		else $error("card check not launched on read");
	AST_CC_SINGLE: assert property ( // RQ12
		card_check_start |-> card_check_single_shot)
		else $error("check running without single-shot mode");

	////////////////////////////////////////////////////////////////////
	// Transmitter conductance by mode and modulation
	wire [3:0] next_cond = reader_mode ?
		(tx_modulating ? pwr_cfg[rfd_pkg::PWR_RMOD +: 4] :
			pwr_cfg[rfd_pkg::PWR_RCW +: 4]) :
		(tx_modulating ? pwr_cfg[rfd_pkg::PWR_CMOD +: 4] :
			pwr_cfg[rfd_pkg::PWR_CCW +: 4]); // RQ15 RQ16

	always_ff @(posedge aclk) begin
		if (!aresetn) tx_conductance <= 4'h0;
		else tx_conductance <= next_cond; // RQ15 RQ16
	end

	AST_TX_RCW: assert property ( // RQ15
		reader_mode && !tx_modulating |=>
		tx_conductance == $past(pwr_cfg[rfd_pkg::PWR_RCW +: 4]))
		else $error("reader carrier conductance not applied");

	assign reader_carrier_level = pwr_cfg[rfd_pkg::PWR_AMP +: 2]; // RQ17
	assign reader_driver_full_swing = pwr_cfg[rfd_pkg::PWR_MAX]; // RQ17
	assign carrier_ref_to_supply = pwr_cfg[rfd_pkg::PWR_REF]; // RQ18

	////////////////////////////////////////////////////////////////////
	// Interrupt: sticky status, write-one clear, enable mask
	wire [4:0] irq_ev = {card_check_done, standby_refused_ev,
		semantic_error_ev, syntax_error_ev, param_error_ev};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st <= '0;
			irq <= 1'b0;
		end else begin
			irq_st <= (irq_st & ~clr_bits) | irq_ev;
			irq <= |(((irq_st & ~clr_bits) | irq_ev) & irq_en);
		end
	end

endmodule : rfd_regs
`default_nettype wire

// *** testbench/tb_rf_detect_status_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_rf_detect_status_config_regs;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic nfc_det_in = 1'b0, rf_det_in = 1'b0, regulator_ok_in = 1'b0;
	logic param_error_ev = 1'b0, syntax_error_ev = 1'b0;
	logic semantic_error_ev = 1'b0, standby_refused_ev = 1'b0;
	logic boot_valid = 1'b0, card_check_done = 1'b0;
	logic [4:0] boot_cause = 5'h00;
	logic [3:0] power_gear_now = 4'h0;
	logic [9:0] gain_control_value = 10'h000;
	logic reader_mode = 1'b0, tx_modulating = 1'b0;
	logic field_present, nfc_detector_power_down, sensor_on;
	logic sensor_hysteresis_on, card_check_start, card_check_single_shot;
	logic reader_driver_full_swing, carrier_ref_to_supply, irq;
	logic [3:0] detect_level, level_detector_ref_upper;
	logic [3:0] level_detector_ref_lower, tx_conductance;
	logic [1:0] temp_trip_sel, reader_carrier_level;
	logic [7:0] temp_trip_deg;
	logic [13:0] low_power_card_detect_ref;
	logic [1:0] last_resp;
	logic [31:0] rdat;
	logic n_i, r_i, e;
	int fail_count = 0;
	int checked = 0;
	int starts = 0;
	localparam logic [7:0] A_DET = {rfd_pkg::IDX_DET, 2'b00};
	localparam logic [7:0] A_SYS = {rfd_pkg::IDX_SYS, 2'b00};
	localparam logic [7:0] A_TEMP = {rfd_pkg::IDX_TEMP, 2'b00};
	localparam logic [7:0] A_CC = {rfd_pkg::IDX_CC, 2'b00};
	localparam logic [7:0] A_PWR = {rfd_pkg::IDX_PWR, 2'b00};
	localparam logic [7:0] A_IST = {rfd_pkg::IDX_IRQ_ST, 2'b00};
	localparam logic [7:0] A_ICLR = {rfd_pkg::IDX_IRQ_CLR, 2'b00};
	localparam logic [7:0] A_IEN = {rfd_pkg::IDX_IRQ_EN, 2'b00};
	logic [7:0] trip [4] = '{rfd_pkg::TRIP_85, rfd_pkg::TRIP_115,
		rfd_pkg::TRIP_125, rfd_pkg::TRIP_135};
	logic [3:0] tx_cond_exp [4] = '{4'h5, 4'hA, 4'hC, 4'h3};

	always #2 aclk = ~aclk;
	always @(posedge aclk) if (card_check_start === 1'b1) starts <= starts + 1;

	rfd_regs rfd_regs_inst (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .nfc_det_in(nfc_det_in), .rf_det_in(rf_det_in),
		.regulator_ok_in(regulator_ok_in), .field_present(field_present),
		.nfc_detector_power_down(nfc_detector_power_down),
		.detect_level(detect_level),
		.level_detector_ref_upper(level_detector_ref_upper),
		.level_detector_ref_lower(level_detector_ref_lower),
		.param_error_ev(param_error_ev), .syntax_error_ev(syntax_error_ev),
		.semantic_error_ev(semantic_error_ev),
		.standby_refused_ev(standby_refused_ev), .boot_valid(boot_valid),
		.boot_cause(boot_cause), .sensor_on(sensor_on),
		.sensor_hysteresis_on(sensor_hysteresis_on),
		.temp_trip_sel(temp_trip_sel), .temp_trip_deg(temp_trip_deg),
		.card_check_start(card_check_start),
		.card_check_single_shot(card_check_single_shot),
		.low_power_card_detect_ref(low_power_card_detect_ref),
		.card_check_done(card_check_done),
		.power_gear_now(power_gear_now),
		.gain_control_value(gain_control_value), .reader_mode(reader_mode),
		.tx_modulating(tx_modulating), .tx_conductance(tx_conductance),
		.reader_carrier_level(reader_carrier_level),
		.reader_driver_full_swing(reader_driver_full_swing),
		.carrier_ref_to_supply(carrier_ref_to_supply), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	task summarize;
		if (fail_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		last_resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] x);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		last_resp = rresp;
		rdat = rdata;
		rready <= 1'b0;
		chk(rdat, x);
	endtask : rd

	task settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		settle(2);
		chk(temp_trip_deg, 32'h0000_0055);
		rd(A_DET, 32'h0000_0000);
		rd(A_SYS, 32'h0000_0000);
		rd(A_TEMP, 32'h0000_0000);
		rd(A_PWR, 32'h0000_0000);
		wr(A_DET, 32'hFFFF_FFFF);
		chk(last_resp, rfd_pkg::RESP_OKAY);
		rd(A_DET, 32'h0000_7FFF);
		chk(last_resp, rfd_pkg::RESP_OKAY);
		settle(6);
		chk({nfc_detector_power_down, detect_level}, 32'h0000_001F);
		chk({level_detector_ref_upper, level_detector_ref_lower}, 32'hFF);
		chk(field_present, 32'h1);
		for (int s = 0; s < 4; s++) begin
			wr(A_DET, 32'(s) << 12);
			for (int k = 0; k < 3; k++) begin
				n_i = (k == 1);
				r_i = (k == 2);
				e = (s == 0) ? n_i : (s == 1) ? r_i : (s == 2) ? (n_i | r_i) : 1'b1;
				@(posedge aclk);
				nfc_det_in <= n_i;
				rf_det_in <= r_i;
				settle(6);
				chk(field_present, e);
			end
		end
		wr(A_DET, 32'h0000_4000);
		@(posedge aclk);
		nfc_det_in <= 1'b1;
		rf_det_in <= 1'b0;
		settle(6);
		chk(field_present, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(A_TEMP, 32'hFFFF_FFFC | i);
			settle(2);
			chk(temp_trip_deg, trip[i]);
			chk(temp_trip_sel, i);
			rd(A_TEMP, 32'h0000_000C | i);
		end
		chk({sensor_on, sensor_hysteresis_on}, 32'h3);
		wr(A_TEMP, 32'h0000_0000);
		settle(2);
		chk({sensor_on, sensor_hysteresis_on}, 32'h0);
		wr(A_PWR, 32'hFFF5_A3C5);
		rd(A_PWR, 32'h0005_A3C5);
		for (int m = 0; m < 4; m++) begin
			@(posedge aclk);
			reader_mode <= m[1];
			tx_modulating <= m[0];
			settle(2);
			chk(tx_conductance, tx_cond_exp[m]);
		end
		chk({reader_carrier_level, reader_driver_full_swing}, 32'h4);
		chk(carrier_ref_to_supply, 32'h1);
		wr(A_IEN, 32'h0000_001E);
		rd(A_IEN, 32'h0000_001E);
		@(posedge aclk);
		param_error_ev <= 1'b1;
		regulator_ok_in <= 1'b1;
		@(posedge aclk);
		param_error_ev <= 1'b0;
		settle(3);
		chk(irq, 32'h0);
		@(posedge aclk);
		syntax_error_ev <= 1'b1;
		semantic_error_ev <= 1'b1;
		standby_refused_ev <= 1'b1;
		boot_valid <= 1'b1;
		boot_cause <= 5'h19;
		@(posedge aclk);
		syntax_error_ev <= 1'b0;
		semantic_error_ev <= 1'b0;
		standby_refused_ev <= 1'b0;
		boot_valid <= 1'b0;
		settle(3);
		chk(irq, 32'h1);
		wr(A_SYS, 32'h0000_0000);
		rd(A_SYS, 32'h0000_03F9);
		rd(A_SYS, 32'h0000_0219);
		rd(A_IST, 32'h0000_000F);
		wr(A_ICLR, 32'h0000_001F);
		rd(A_IST, 32'h0000_0000);
		settle(2);
		chk(irq, 32'h0);
		@(posedge aclk);
		power_gear_now <= 4'h9;
		gain_control_value <= 10'h2A5;
		rd(A_CC, 32'h0000_0000);
		settle(1);
		chk(starts, 32'h1);
		chk(card_check_single_shot, 32'h1);
		@(posedge aclk);
		card_check_done <= 1'b1;
		@(posedge aclk);
		card_check_done <= 1'b0;
		settle(2);
		chk(card_check_single_shot, 32'h0);
		rd(A_CC, 32'h0000_26A5);
		wr(A_CC, 32'hFFFF_3123);
		settle(1);
		chk(low_power_card_detect_ref, 32'h0000_3123);
		chk(starts, 32'h2);
		wr(8'h00, 32'h0000_0001);
		chk(last_resp, rfd_pkg::RESP_SLVERR);
		rd(8'hFC, 32'h0000_0000);
		chk(last_resp, rfd_pkg::RESP_SLVERR);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		summarize();
	end
endmodule : tb_rf_detect_status_config_regs
`default_nettype wire
